/* File: shared/can_tx_cfg.svh */
`ifndef CAN_TX_CFG_SVH
`define CAN_TX_CFG_SVH

// packed word stream layout
`define FRAME_WORDS 20
`define HDR_WORDS 4
`define WORD_TS_HI 0
`define WORD_TS_LO 1
`define WORD_ID 2
`define WORD_INFO 3
`define PAYLOAD_BYTES 64

// identifier and frame type fields
`define ID_EXT_BIT 29
`define KIND_CLASSIC 8'h00
`define KIND_REMOTE 8'h01
`define KIND_FD 8'h10
`define KIND_FD_BRS 8'h18
`define CLASSIC_MAX_LEN 8'h08
`define FD_MAX_LEN 8'h40

// timing and queue depth
`define CLK_KHZ 100000
`define WAIT_UNIT_MS 1
`define MS_CYCLES (`CLK_KHZ * `WAIT_UNIT_MS)
`define RETRY_CYCLES 16
`define FIFO_DEPTH 4

`endif

/* File: shared/can_tx_pkg.sv */
`include "can_tx_cfg.svh"

package can_tx_pkg;

    typedef enum logic [7:0] {
        KIND_CLASSIC = `KIND_CLASSIC,
        KIND_REMOTE = `KIND_REMOTE,
        KIND_FD = `KIND_FD,
        KIND_FD_BRS = `KIND_FD_BRS
    } frame_kind_type;

    typedef struct packed {
        logic [31:0] id;
        logic [7:0] kind;
        logic [7:0] len;
        logic [8*`PAYLOAD_BYTES-1:0] data;
    } tx_frame_type;

endpackage

/* File: shared/can_tx_if.sv */
`timescale 1ns/1ns
`default_nettype none

interface can_tx_if;
    logic wr_valid;
    logic wr_ready;
    logic [31:0] wr_word;
    logic done;
    logic err;
    logic start;
    logic started;
    logic tx_idle;

    modport dev (
        input wr_valid,
        output wr_ready,
        input wr_word,
        output done,
        output err,
        input start,
        output started,
        output tx_idle
    );

    modport writer (
        output wr_valid,
        input wr_ready,
        output wr_word,
        input done,
        input err,
        output start,
        input started,
        input tx_idle
    );
endinterface

`default_nettype wire

/* File: rtl/frame_queue.sv */
`timescale 1ns/1ns
`default_nettype none

module frame_queue #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // fill side
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    output logic full,
    // drain side
    input wire logic pop,
    output logic empty,
    output logic [WIDTH-1:0] head
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    wire do_push = push && !full;
    wire do_pop = pop && !empty;
    wire [AW-1:0] wr_next = (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
    wire [AW-1:0] rd_next = (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;

    assign full = (count_q == (AW + 1)'(DEPTH));
    assign empty = (count_q == '0);
    assign head = mem_q[rd_ptr_q];

    always_ff @(posedge sys_clk) begin
        if (do_push) begin
            mem_q[wr_ptr_q] <= push_data;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_q <= wr_next;
            end
            if (do_pop) begin
                rd_ptr_q <= rd_next;
            end
            count_q <= count_q + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
        end
    end
endmodule // frame_queue

`default_nettype wire

/* File: rtl/can_tx_device.sv */
// Notes on behaviour
// RL1 - write stalls until queue slot is free
// RL2 - frame into empty queue transmits at once
// RL3 - write completes on queueing, not acknowledgment
// RL4 - writer waits transmit complete for one-at-a-time
// RL5 - queued frames go to controller without gaps
// RL6 - slot frees only after successful transmission
// RL7 - full queue waits at most wait limit ms
// RL8 - zero wait limit returns error at once
// RL9 - writer retries same frame after an error
// RL10 - writer starts the port before writing frames
// RL11 - writes execute in order; blocked one delays rest
// RL12 - requested frame type within configured mode
// RL13 - timestamp words ignored; send as soon as possible
// RL14 - identifier bit 29 selects extended format
// RL15 - type codes 0, 1, 16, 24
// RL16 - length limited to 8 classic, 64 FD
// RL17 - remote frame length is bytes requested
// RL18 - fixed 64-byte payload, only length bytes sent
// RL19 - packed word order and byte placement
// RL20 - reserved info bytes accepted and ignored
`timescale 1ns/1ns
`default_nettype none
`include "can_tx_cfg.svh"

module can_tx_device
    import can_tx_pkg::*;
#(
    parameter int FIFO_DEPTH = `FIFO_DEPTH,
    parameter int MS_CYCLES = `MS_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // link to the writing logic
    can_tx_if.dev link,
    // port configuration
    input wire logic auto_start,
    input wire logic [15:0] output_wait_limit,
    // bus controller side
    output logic ctl_valid,
    input wire logic ctl_take,
    input wire logic ctl_sent,
    output logic [28:0] ctl_id,
    output logic ctl_ext,
    output logic [7:0] ctl_kind,
    output logic [7:0] ctl_len,
    output logic [8*`PAYLOAD_BYTES-1:0] ctl_data
);
    localparam int FW = $bits(tx_frame_type);

    typedef enum logic [1:0] {
        ST_COLLECT,
        ST_PLACE,
        ST_WAIT
    } dev_state_type;

    dev_state_type state_q;
    logic [4:0] wcnt_q;
    tx_frame_type frame_q;
    logic [31:0] ms_cyc_q;
    logic [15:0] ms_done_q;
    logic ready_q;
    logic done_q;
    logic err_q;
    logic started_q;
    logic idle_q;
    logic busy_q;
    logic ctl_valid_q;
    tx_frame_type out_q;

    // word intake
    wire take_word = link.wr_valid && ready_q;
    wire last_word = (wcnt_q == 5'(`FRAME_WORDS - 1));
    wire [3:0] pay_idx = 4'(wcnt_q - 5'(`HDR_WORDS));
    wire [31:0] w = link.wr_word;
    wire [31:0] w_swap = {w[7:0], w[15:8], w[23:16], w[31:24]};

    // frame normalisation before queueing
    wire is_remote = (frame_q.kind == `KIND_REMOTE);
    wire is_fd = (frame_q.kind == `KIND_FD) || (frame_q.kind == `KIND_FD_BRS);
    wire [7:0] max_len = is_fd ? `FD_MAX_LEN : `CLASSIC_MAX_LEN;
    wire [7:0] norm_len = (frame_q.len > max_len) ? max_len : frame_q.len; // RL16 RL17
    logic [8*`PAYLOAD_BYTES-1:0] norm_data;
    always_comb begin
        norm_data = '0;
        for (int i = 0; i < `PAYLOAD_BYTES; i++) begin
            if (!is_remote && (8'(i) < norm_len)) begin
                norm_data[8*i +: 8] = frame_q.data[8*i +: 8]; // RL18
            end
        end
    end
    wire tx_frame_type norm_frame = '{id: frame_q.id, kind: frame_q.kind, len: norm_len, data: norm_data};

    // queue control
    logic q_full;
    logic q_empty;
    logic [FW-1:0] q_head;
    wire placing = (state_q == ST_PLACE) || (state_q == ST_WAIT);
    wire push = placing && started_q && !q_full; // RL1
    wire limit_zero = (output_wait_limit == 16'h0000);
    wire ms_tick = (ms_cyc_q == 32'(MS_CYCLES - 1));
    wire expired = ms_tick && ((ms_done_q + 16'h0001) >= output_wait_limit); // RL7
    wire refuse_now = (state_q == ST_PLACE) && (!started_q || (q_full && limit_zero)); // RL8
    wire refuse_wait = (state_q == ST_WAIT) && q_full && expired;
    wire answer = push || refuse_now || refuse_wait;
    wire pop = busy_q && ctl_sent; // RL6
    wire offer = !q_empty && !busy_q && !ctl_valid_q; // RL2 RL5

    frame_queue #(
        .WIDTH(FW),
        .DEPTH(FIFO_DEPTH)
    ) u_queue (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .push(push),
        .push_data(norm_frame),
        .full(q_full),
        .pop(pop),
        .empty(q_empty),
        .head(q_head)
    );

    // state sequence; intake closes while a frame is being placed, so later writes wait
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_COLLECT;
            wcnt_q <= '0;
            ready_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_COLLECT: begin
                    ready_q <= !(take_word && last_word);
                    if (take_word) begin
                        wcnt_q <= last_word ? 5'h00 : wcnt_q + 5'h01;
                        if (last_word) begin
                            state_q <= ST_PLACE; // RL11
                        end
                    end
                end
                ST_PLACE: begin
                    if (answer) begin
                        state_q <= ST_COLLECT;
                        ready_q <= 1'b1;
                    end else begin
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (answer) begin
                        state_q <= ST_COLLECT;
                        ready_q <= 1'b1;
                    end
                end
            endcase
        end
    end

    // frame assembly from the packed words
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            frame_q <= '0;
        end else if (take_word) begin
            if (wcnt_q == 5'(`WORD_ID)) begin
                frame_q.id <= w; // RL14
            end else if (wcnt_q == 5'(`WORD_INFO)) begin
                frame_q.kind <= w[31:24]; // RL15 RL19
                frame_q.len <= w[7:0]; // RL20
            end else if (wcnt_q >= 5'(`HDR_WORDS)) begin
                frame_q.data[{pay_idx, 5'h00} +: 32] <= w_swap; // RL19
            end
            // timestamp words fall through untouched
        end
    end

    // wait-limit timer, counted in whole milliseconds
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ms_cyc_q <= '0;
            ms_done_q <= '0;
        end else if (state_q != ST_WAIT) begin
            ms_cyc_q <= '0;
            ms_done_q <= '0;
        end else if (ms_tick) begin
            ms_cyc_q <= '0;
            ms_done_q <= ms_done_q + 16'h0001;
        end else begin
            ms_cyc_q <= ms_cyc_q + 32'h00000001;
        end
    end

    // write result; completes on queueing, no acknowledgment awaited
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            done_q <= 1'b0;
            err_q <= 1'b0;
            started_q <= 1'b0;
            idle_q <= 1'b1;
        end else begin
            done_q <= answer; // RL3
            err_q <= answer && !push;
            started_q <= started_q || auto_start || link.start;
            // idle drops on the push edge so a waiting writer never sees a stale idle
            idle_q <= q_empty && !push && !busy_q && !ctl_valid_q && !offer;
        end
    end

    // controller hand-off; the slot stays held until the controller reports success
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctl_valid_q <= 1'b0;
            busy_q <= 1'b0;
            out_q <= '0;
        end else begin
            if (offer) begin
                ctl_valid_q <= 1'b1; // RL2 RL13
                out_q <= q_head;
            end else if (ctl_valid_q && ctl_take) begin
                ctl_valid_q <= 1'b0;
                busy_q <= 1'b1;
            end
            if (pop) begin
                busy_q <= 1'b0; // RL5
            end
        end
    end

    assign link.wr_ready = ready_q;
    assign link.done = done_q;
    assign link.err = err_q;
    assign link.started = started_q;
    assign link.tx_idle = idle_q;
    assign ctl_valid = ctl_valid_q;
    assign ctl_id = out_q.id[28:0];
    assign ctl_ext = out_q.id[`ID_EXT_BIT]; // RL14
    assign ctl_kind = out_q.kind;
    assign ctl_len = out_q.len;
    assign ctl_data = out_q.data;
endmodule // can_tx_device

`default_nettype wire

/* File: rtl/can_tx_writer.sv */
`timescale 1ns/1ns
`default_nettype none
`include "can_tx_cfg.svh"

module can_tx_writer
    import can_tx_pkg::*;
#(
    parameter int RETRY_CYCLES = `RETRY_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // link to the device
    can_tx_if.writer link,
    // frame submission
    input wire logic sub_valid,
    output logic sub_ready,
    input wire logic [31:0] ts_hi,
    input wire logic [31:0] ts_lo,
    input wire logic [31:0] frame_id,
    input wire logic [7:0] frame_kind,
    input wire logic [7:0] reserved_info_byte_a,
    input wire logic [7:0] reserved_info_byte_b,
    input wire logic [7:0] frame_len,
    input wire logic [8*`PAYLOAD_BYTES-1:0] frame_data,
    // options
    input wire logic one_at_a_time,
    input wire logic fd_mode,
    // result
    output logic sub_done,
    output logic sub_err
);
    typedef enum logic [2:0] {
        WS_IDLE,
        WS_START,
        WS_LOAD,
        WS_SEND,
        WS_RESP,
        WS_RETRY,
        WS_DRAIN
    } wr_state_type;

    wr_state_type state_q;
    logic [31:0] hdr_q [`HDR_WORDS];
    logic [8*`PAYLOAD_BYTES-1:0] data_q;
    logic [4:0] idx_q;
    logic [15:0] retry_q;
    logic valid_q;
    logic [31:0] word_q;
    logic start_q;
    logic ready_q;
    logic done_q;
    logic err_q;

    wire sent = valid_q && link.wr_ready;
    wire last = (idx_q == 5'(`FRAME_WORDS - 1));
    wire [4:0] nidx = idx_q + 5'h01;
    wire kind_fd = (frame_kind == `KIND_FD) || (frame_kind == `KIND_FD_BRS);
    wire kind_bad = kind_fd && !fd_mode; // RL12

    function automatic logic [31:0] word_at(input logic [4:0] i);
        logic [3:0] k;
        k = 4'(i - 5'(`HDR_WORDS));
        if (i < 5'(`HDR_WORDS)) begin
            word_at = hdr_q[i[1:0]];
        end else begin
            word_at = {data_q[{k, 5'h00} +: 8], data_q[{k, 2'h1, 3'h0} +: 8],
                       data_q[{k, 2'h2, 3'h0} +: 8], data_q[{k, 2'h3, 3'h0} +: 8]}; // RL19
        end
    endfunction

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= WS_IDLE;
            for (int i = 0; i < `HDR_WORDS; i++) begin
                hdr_q[i] <= '0;
            end
            data_q <= '0;
            idx_q <= '0;
            retry_q <= '0;
            valid_q <= 1'b0;
            word_q <= '0;
            start_q <= 1'b0;
            ready_q <= 1'b0;
            done_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            start_q <= 1'b0;
            unique case (state_q)
                WS_IDLE: begin
                    ready_q <= 1'b1;
                    if (sub_valid && ready_q) begin
                        ready_q <= 1'b0;
                        hdr_q[`WORD_TS_HI] <= ts_hi;
                        hdr_q[`WORD_TS_LO] <= ts_lo;
                        hdr_q[`WORD_ID] <= frame_id;
                        hdr_q[`WORD_INFO] <= {frame_kind, reserved_info_byte_a, reserved_info_byte_b, frame_len};
                        data_q <= frame_data;
                        if (kind_bad) begin
                            done_q <= 1'b1;
                            err_q <= 1'b1;
                            state_q <= WS_IDLE;
                        end else begin
                            state_q <= link.started ? WS_LOAD : WS_START;
                        end
                    end
                end
                WS_START: begin
                    start_q <= !link.started; // RL10
                    if (link.started) begin
                        state_q <= WS_LOAD;
                    end
                end
                WS_LOAD: begin
                    idx_q <= '0;
                    word_q <= word_at(5'h00);
                    valid_q <= 1'b1;
                    state_q <= WS_SEND;
                end
                WS_SEND: begin
                    if (sent) begin
                        if (last) begin
                            valid_q <= 1'b0;
                            state_q <= WS_RESP;
                        end else begin
                            idx_q <= nidx;
                            word_q <= word_at(nidx);
                        end
                    end
                end
                WS_RESP: begin
                    if (link.done) begin
                        if (link.err) begin
                            retry_q <= '0;
                            state_q <= WS_RETRY; // RL9
                        end else if (one_at_a_time) begin
                            state_q <= WS_DRAIN;
                        end else begin
                            done_q <= 1'b1;
                            err_q <= 1'b0;
                            state_q <= WS_IDLE;
                        end
                    end
                end
                WS_RETRY: begin
                    retry_q <= retry_q + 16'h0001;
                    if (retry_q == 16'(RETRY_CYCLES - 1)) begin
                        state_q <= link.started ? WS_LOAD : WS_START;
                    end
                end
                WS_DRAIN: begin
                    if (link.tx_idle) begin
                        done_q <= 1'b1; // RL4
                        err_q <= 1'b0;
                        state_q <= WS_IDLE;
                    end
                end
            endcase
        end
    end

    assign link.wr_valid = valid_q;
    assign link.wr_word = word_q;
    assign link.start = start_q;
    assign sub_ready = ready_q;
    assign sub_done = done_q;
    assign sub_err = err_q;
endmodule // can_tx_writer

`default_nettype wire

/* File: verif/can_tx_asserts.sv */
`timescale 1ns/1ns
`default_nettype none

module can_tx_asserts (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // word link
    input wire logic wr_valid,
    input wire logic wr_ready,
    input wire logic [31:0] wr_word,
    input wire logic done,
    input wire logic err,
    // port state
    input wire logic start,
    input wire logic started,
    input wire logic tx_idle
);
    logic [4:0] wcnt_q;
    logic [4:0] wcnt_d;
    logic pending_q;
    logic pending_d;
    wire take = wr_valid && wr_ready;
    wire take_last = take && (wcnt_q == 5'h13);

    // word position inside the 20-word frame
    assign wcnt_d = !take ? wcnt_q : take_last ? 5'h00 : wcnt_q + 5'h01;
    assign pending_d = take_last ? 1'b1 : done ? 1'b0 : pending_q;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wcnt_q <= 5'h00;
            pending_q <= 1'b0;
        end else begin
            wcnt_q <= wcnt_d;
            pending_q <= pending_d;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    chk_done_pulse: assert property (done |=> !done)
        else $error("done wider than one cycle");
    chk_done_cause: assert property (done |-> pending_q)
        else $error("done without a finished frame");
    chk_ready_stall: assert property (take_last |=> !wr_ready ##1 (wr_ready == done))
        else $error("ready while frame is being placed");
    chk_done_prompt: assert property (take_last && tx_idle |=> !done ##1 done)
        else $error("empty queue did not answer promptly");
    chk_done_bound: assert property ($rose(pending_q) |-> ##[1:200] done)
        else $error("write wait not bounded");
    chk_no_word_wait: assert property (pending_q |-> !wr_valid)
        else $error("next frame offered before answer");
    chk_idle_drops: assert property (done && !err |-> ##[0:2] !tx_idle)
        else $error("queued frame left idle high");
    chk_start_taken: assert property (start |=> started)
        else $error("start not taken");
    chk_start_sticky: assert property (started |=> started)
        else $error("started fell");
    chk_kind_legal: assert property (take && (wcnt_q == 5'h03) |-> (wr_word[31:24] inside {8'h00, 8'h01, 8'h10, 8'h18}))
        else $error("illegal frame type word");

    cover property (done && err);
    cover property (done && !err);
    cover property (take_last && !tx_idle);
endmodule // can_tx_asserts

`default_nettype wire

/* File: verif/testbench.sv */
`timescale 1ns/1ns
`default_nettype none

module testbench;
    import can_tx_pkg::*;
    localparam int DEPTH = 2;
    localparam int MS = 20;
    logic sys_clk, rstn, auto_start, ctl_take, ctl_sent, sub_valid, one_at_a_time, fd_mode;
    logic ctl_valid, ctl_ext, sub_ready, sub_done, sub_err;
    logic [15:0] output_wait_limit;
    logic [31:0] ts_hi, ts_lo, frame_id, rid;
    logic [7:0] frame_kind, reserved_info_byte_a, reserved_info_byte_b, frame_len, ctl_kind, ctl_len;
    logic [511:0] frame_data, ctl_data;
    logic [28:0] ctl_id;
    logic [31:0] exp_w [20];
    logic [7:0] kinds [4] = '{8'h00, 8'h01, 8'h10, 8'h18};
    logic [7:0] lens [6] = '{8'h00, 8'h08, 8'h09, 8'h40, 8'h41, 8'hFF};
    int n_fail = 0;
    int comparisons = 0;
    int seed = 32'hA93A;
    int occ = 0;
    int wi = 0;
    int cyc = 0;
    int dly = 0;
    bit go = 1;
    bit busy = 0;
    bit gap = 0;
    bit gap2 = 0;
    bit was_sent = 0;
    tx_frame_type f;
    tx_frame_type exp_q [$];

    can_tx_if link();
    can_tx_device #(.FIFO_DEPTH(DEPTH), .MS_CYCLES(MS)) u_can_tx_device (.sys_clk(sys_clk), .rstn(rstn),
        .link(link), .auto_start(auto_start), .output_wait_limit(output_wait_limit), .ctl_valid(ctl_valid),
        .ctl_take(ctl_take), .ctl_sent(ctl_sent), .ctl_id(ctl_id), .ctl_ext(ctl_ext), .ctl_kind(ctl_kind),
        .ctl_len(ctl_len), .ctl_data(ctl_data));
    can_tx_writer u_can_tx_writer (.sys_clk(sys_clk), .rstn(rstn), .link(link), .sub_valid(sub_valid),
        .sub_ready(sub_ready), .ts_hi(ts_hi), .ts_lo(ts_lo), .frame_id(frame_id), .frame_kind(frame_kind),
        .reserved_info_byte_a(reserved_info_byte_a), .reserved_info_byte_b(reserved_info_byte_b),
        .frame_len(frame_len), .frame_data(frame_data), .one_at_a_time(one_at_a_time), .fd_mode(fd_mode),
        .sub_done(sub_done), .sub_err(sub_err));
    can_tx_asserts u_can_tx_asserts (.sys_clk(sys_clk), .rstn(rstn), .wr_valid(link.wr_valid),
        .wr_ready(link.wr_ready), .wr_word(link.wr_word), .done(link.done), .err(link.err),
        .start(link.start), .started(link.started), .tx_idle(link.tx_idle));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [511:0] seen, input logic [511:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        if (n_fail == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // reference frame as the controller must see it
    function automatic tx_frame_type expect_of(logic [31:0] id, logic [7:0] k, logic [7:0] l, logic [511:0] d);
        tx_frame_type r;
        logic [7:0] mx;
        mx = (k == KIND_FD || k == KIND_FD_BRS) ? 8'h40 : 8'h08;
        r.id = id;
        r.kind = k;
        r.len = (l > mx) ? mx : l;
        r.data = '0;
        for (int i = 0; i < 64; i++)
            if (k != KIND_REMOTE && i < r.len) r.data[8*i+:8] = d[8*i+:8];
        return r;
    endfunction

    task automatic submit(input logic [31:0] id, input logic [7:0] k, input logic [7:0] l, input logic exp_err);
        logic [511:0] d;
        int n;
        for (int i = 0; i < 16; i++) d[32*i+:32] = $random(seed);
        exp_w[0] = $random(seed);
        exp_w[1] = $random(seed);
        exp_w[2] = id;
        exp_w[3] = {k, 16'(($random(seed))), l};
        for (int j = 0; j < 16; j++) exp_w[4+j] = {d[32*j+:8], d[32*j+8+:8], d[32*j+16+:8], d[32*j+24+:8]};
        @(posedge sys_clk);
        ts_hi <= exp_w[0];
        ts_lo <= exp_w[1];
        frame_id <= id;
        frame_kind <= k;
        reserved_info_byte_a <= exp_w[3][23:16];
        reserved_info_byte_b <= exp_w[3][15:8];
        frame_len <= l;
        frame_data <= d;
        sub_valid <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (sub_ready !== 1'b1 && n < 100);
        sub_valid <= 1'b0;
        if (!exp_err) exp_q.push_back(expect_of(id, k, l, d));
        n = 0;
        while (sub_done !== 1'b1 && n < 3000) begin
            @(posedge sys_clk);
            n++;
        end
        chk(n < 3000, 1'b1);
        chk(sub_err, exp_err);
        if (one_at_a_time) chk(occ == 0, 1'b1);
    endtask

    task automatic drain();
        int n;
        n = 0;
        while (occ != 0 && n < 5000) begin
            @(posedge sys_clk);
            n++;
        end
        chk(n < 5000, 1'b1);
    endtask

    // controller stand-in and link monitor; a stall holds the slot taken
    always @(posedge sys_clk) begin
        cyc++;
        // next offer shows two edges after the success pulse
        if (gap2) chk(ctl_valid, 1'b1);
        gap2 = gap;
        if (link.wr_valid && link.wr_ready) begin
            chk(link.wr_word, exp_w[wi]);
            if (wi == 19) cyc = 0;
            wi = (wi + 1) % 20;
        end
        // fill level as the device saw it one edge earlier, before that edge's pop
        if (link.done) begin
            if (output_wait_limit == 0 && !go) chk(link.err, occ + was_sent >= DEPTH);
            else if (link.err) chk(occ + was_sent >= DEPTH && cyc >= output_wait_limit * MS
                && cyc <= output_wait_limit * MS + 6, 1'b1);
            if (!link.err) occ++;
        end
        if (ctl_sent) occ--;
        was_sent = ctl_sent;
        gap = ctl_sent && occ > 0;
        if (busy && go && dly == 0) begin
            ctl_sent <= 1'b1;
            busy = 0;
        end else begin
            ctl_sent <= 1'b0;
            if (busy && go) dly--;
        end
        if (ctl_valid && ctl_take) begin
            chk(exp_q.size() != 0, 1'b1);
            f = exp_q.pop_front();
            chk(ctl_ext, f.id[29]);
            if (f.id[29]) chk(ctl_id, f.id[28:0]);
            else chk(ctl_id[10:0], f.id[10:0]);
            chk(ctl_kind, f.kind);
            chk(ctl_len, f.len);
            chk(ctl_data, f.data);
            busy = 1;
            dly = $random(seed) & 7;
            ctl_take <= 1'b0;
        end else
            ctl_take <= ctl_valid && go && !busy && (($random(seed) & 1) != 0);
    end

    initial begin
        rstn = 1'b0;
        {auto_start, ctl_take, ctl_sent, sub_valid, one_at_a_time, fd_mode} = '0;
        {ts_hi, ts_lo, frame_id, frame_kind, frame_len, frame_data} = '0;
        {reserved_info_byte_a, reserved_info_byte_b} = '0;
        output_wait_limit = 16'h0003;
        repeat (5) @(posedge sys_clk);
        rstn <= 1'b1;
        fd_mode <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            rid = $random(seed);
            rid[29] = i[0];
            submit(rid, kinds[i % 4], lens[i % 6], 1'b0);
        end
        fd_mode <= 1'b0;
        submit(rid, KIND_FD, 8'h05, 1'b1);
        submit(rid, KIND_CLASSIC, 8'h05, 1'b0);
        fd_mode <= 1'b1;
        // stalled controller: zero limit refuses, then a timed wait expires
        for (int s = 0; s < 2; s++) begin
            drain();
            go <= 1'b0;
            output_wait_limit <= (s == 0) ? 16'h0000 : 16'h0002;
            for (int i = 0; i < DEPTH; i++) submit($random(seed), KIND_CLASSIC, 8'h08, 1'b0);
            fork
                submit($random(seed), KIND_FD_BRS, 8'h40, 1'b0);
                begin
                    repeat (s == 0 ? 90 : 120) @(posedge sys_clk);
                    go <= 1'b1;
                end
            join
        end
        drain();
        output_wait_limit <= 16'h0003;
        one_at_a_time <= 1'b1;
        for (int i = 0; i < 3; i++) submit($random(seed), KIND_REMOTE, 8'h04, 1'b0);
        drain();
        report_and_stop();
    end

    initial begin
        #1000000;
        n_fail++;
        report_and_stop();
    end
endmodule // testbench

`default_nettype wire
